//--- fpes_top.sv
/*
 Program, erase, suspend and resume sequencer of a serial flash device.
 Link pins come from the host asynchronously and are synchronised here;
 the memory array takes operation requests over ARR_* and reads the page
 buffer through PB_*; protection lookup is answered by same-clock logic.
*/
`timescale 1ns/1ps

module fpes_top #(
   parameter logic [fpes_pkg::TMR_W-1:0] PP_CYC = 24'h0007d0,
   parameter logic [fpes_pkg::TMR_W-1:0] SE_CYC = 24'h000fa0,
   parameter logic [fpes_pkg::TMR_W-1:0] BE32_CYC = 24'h001770,
   parameter logic [fpes_pkg::TMR_W-1:0] BE64_CYC = 24'h001f40,
   parameter logic [fpes_pkg::TMR_W-1:0] CE_CYC = 24'h003e80,
   parameter logic [fpes_pkg::TMR_W-1:0] SUS_CYC = 24'h0000c8
) (
   input logic REF_CLK,
   input logic RST_B,
   input logic CLK_EN,
   input logic LINK_SCLK,
   input logic LINK_CS_B,
   input logic [3:0] LINK_IO,
   input logic QUAD_LANE_ENABLE_BIT,
   input logic PROT_HIT,
   input logic PROT_ANY,
   output logic [23:0] PROT_ADDR,
   output logic BUSY,
   output logic WRITE_ENABLE_LATCH,
   output logic SUSPEND_FLAG,
   output logic ARR_VALID,
   input logic ARR_READY,
   output fpes_pkg::fpes_req_s ARR_REQ,
   input logic [7:0] PB_RADDR,
   output logic [7:0] PB_RDATA
);

   localparam int SUS_LAT = int'(SUS_CYC) + 1;
   localparam int RESUME_LIM = fpes_pkg::RESUME_CYC;

   logic [5:0] lnk_s;
   logic sck_d_r;
   logic cs_d_r;
   logic [7:0] sh_r;
   logic [3:0] bc_r;
   logic [9:0] nb_r;
   logic quad_r;
   logic [7:0] opc_r;
   logic [23:0] addr_r;
   logic [7:0] pb_ptr_r;
   logic [7:0] pb_mem [fpes_pkg::PAGE_BYTES];
   fpes_pkg::fpes_eng_s eng_r, eng_nxt, sv_r, sv_nxt;
   fpes_pkg::fpes_req_s req_r, req_nxt;
   logic [fpes_pkg::TMR_W-1:0] lat_r, lat_nxt;
   logic sus_r, sus_nxt;
   logic wel_r, wel_nxt;
   logic q_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Link sampling. The host clock is sampled, not used as a clock, so the
   // link must run well below a quarter of REF_CLK.

   fpes_sync #(.W(6), .RST_VAL(fpes_pkg::SYNC_RST)) u_sync (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .ce(CLK_EN),
      .d({LINK_CS_B, LINK_SCLK, LINK_IO}),
      .q(lnk_s)
   );

   wire cs_b_s = lnk_s[5];
   wire sck_s = lnk_s[4];
   wire [3:0] io_s = lnk_s[3:0];
   wire sck_rise = sck_s & ~sck_d_r & ~cs_b_s;
   wire frm_end = cs_b_s & ~cs_d_r;
   wire [3:0] step = quad_r ? 4'h4 : 4'h1;
   wire [3:0] bc_nxt = bc_r + step;
   wire [7:0] sh_nxt = quad_r ? {sh_r[3:0], io_s} : {sh_r[6:0], io_s[0]};
   wire byte_done = sck_rise & bc_nxt[3];
   wire [9:0] nb_inc = (nb_r == fpes_pkg::NB_MAX) ? nb_r : nb_r + 10'h001;
   wire idle = eng_r.st == fpes_pkg::ST_IDLE;
   // The page buffer is frozen while an operation holds it, running or suspended, so that
   // a refused frame during a program suspension cannot corrupt the data still to be written.
   wire pb_we = byte_done && (nb_r > fpes_pkg::NB_ADDR_LAST) && idle &&
                !(sus_r && sv_r.kind == fpes_pkg::FPES_OP_PP);

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else if (CLK_EN) begin
         sck_d_r <= sck_s;
         cs_d_r <= cs_b_s;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sh_r <= 8'h00;
         bc_r <= 4'h0;
         nb_r <= 10'h000;
         quad_r <= 1'b0;
         opc_r <= 8'h00;
         addr_r <= 24'h000000;
         pb_ptr_r <= 8'h00;
      end else if (CLK_EN) begin
         if (cs_b_s) begin
            bc_r <= 4'h0;
            nb_r <= 10'h000;
            quad_r <= 1'b0;
         end else if (sck_rise) begin
            sh_r <= sh_nxt;
            bc_r <= byte_done ? 4'h0 : bc_nxt;
            if (byte_done) begin
               nb_r <= nb_inc;
               if (nb_r == 10'h000) begin
                  opc_r <= sh_nxt;
                  quad_r <= sh_nxt == fpes_pkg::OPC_QPP;
               end
               if (nb_r != 10'h000 && nb_r <= fpes_pkg::NB_ADDR_LAST) begin
                  addr_r <= {addr_r[15:0], sh_nxt};
               end
               if (nb_r == fpes_pkg::NB_ADDR_LAST) pb_ptr_r <= sh_nxt;
               if (pb_we) pb_ptr_r <= pb_ptr_r + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (CLK_EN && pb_we) pb_mem[pb_ptr_r] <= sh_nxt;
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) PB_RDATA <= 8'h00;
      else if (CLK_EN) PB_RDATA <= pb_mem[PB_RADDR];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode at the rising edge of chip select.

   function automatic logic [fpes_pkg::TMR_W-1:0] dur(input fpes_pkg::fpes_op_e k);
      case (k)
         fpes_pkg::FPES_OP_PP: dur = PP_CYC;
         fpes_pkg::FPES_OP_SE: dur = SE_CYC;
         fpes_pkg::FPES_OP_BE32: dur = BE32_CYC;
         fpes_pkg::FPES_OP_BE64: dur = BE64_CYC;
         default: dur = CE_CYC;
      endcase
   endfunction

   fpes_pkg::fpes_op_e new_kind;
   assign new_kind = fpes_pkg::op_of(opc_r);

   wire whole = bc_r == 4'h0;
   wire one = whole && nb_r == fpes_pkg::NB_CMD;
   wire is_ce = new_kind == fpes_pkg::FPES_OP_CE;
   wire is_pp = new_kind == fpes_pkg::FPES_OP_PP;
   // Any trailing partial byte discards the command, and so does any extra byte except on a program.
   wire len_ok = whole && (is_ce ? nb_r == fpes_pkg::NB_CMD :
                           is_pp ? nb_r >= fpes_pkg::NB_PROG_MIN :
                           nb_r == fpes_pkg::NB_ERASE);
   wire qe_ok = (opc_r != fpes_pkg::OPC_QPP) || QUAD_LANE_ENABLE_BIT;
   wire prot_ok = is_ce ? ~PROT_ANY : ~PROT_HIT;
   wire bar_ok = ~sus_r || (fpes_pkg::is_erase(sv_r.kind) ? ~fpes_pkg::is_erase(new_kind) :
                            ~is_pp);
   wire launch = frm_end && new_kind != fpes_pkg::FPES_OP_NONE && len_ok && wel_r && idle &&
                 qe_ok && prot_ok && bar_ok;
   wire sus_go = frm_end && one && opc_r == fpes_pkg::OPC_SUS &&
                 eng_r.st == fpes_pkg::ST_RUN && ~sus_r &&
                 eng_r.kind != fpes_pkg::FPES_OP_CE;
   wire res_go = frm_end && one && opc_r == fpes_pkg::OPC_RES && sus_r && idle;
   wire wren = frm_end && one && opc_r == fpes_pkg::OPC_WREN && idle;
   wire wrdi = frm_end && one && opc_r == fpes_pkg::OPC_WRDI && idle;
   wire [9:0] ndata = nb_r - fpes_pkg::NB_ERASE;
   wire [8:0] nb_pg = (ndata >= fpes_pkg::NB_PAGE) ? 9'h100 : ndata[8:0];

   ////////////////////////////////////////////////////////////////////////////
   // Self-timed engine with one suspended slot. A newly started operation
   // runs in the active slot while the suspended one waits in sv_r.

   always_comb begin
      eng_nxt = eng_r;
      sv_nxt = sv_r;
      req_nxt = req_r;
      lat_nxt = lat_r;
      sus_nxt = sus_r;
      wel_nxt = wel_r;
      case (eng_r.st)
         fpes_pkg::ST_IDLE: begin
            if (launch) begin
               eng_nxt.st = fpes_pkg::ST_QUEUE;
               eng_nxt.kind = new_kind;
               eng_nxt.cnt = dur(new_kind);
               req_nxt.kind = new_kind;
               req_nxt.addr = addr_r;
               req_nxt.nbytes = is_pp ? nb_pg : 9'h000;
            end else if (res_go) begin
               eng_nxt = sv_r;
               eng_nxt.st = fpes_pkg::ST_RUN;
               sus_nxt = 1'b0;
            end else if (wren) begin
               wel_nxt = 1'b1;
            end else if (wrdi) begin
               wel_nxt = 1'b0;
            end
         end
         fpes_pkg::ST_QUEUE: begin
            // Timing starts only once the request queue accepts the request.
            if (q_ready) eng_nxt.st = fpes_pkg::ST_RUN;
         end
         fpes_pkg::ST_RUN: begin
            if (sus_go) begin
               eng_nxt.st = fpes_pkg::ST_SUSW;
               sus_nxt = 1'b1;
               lat_nxt = SUS_CYC;
            end else if (eng_r.cnt <= 24'h000001) begin
               eng_nxt.st = fpes_pkg::ST_IDLE;
               eng_nxt.kind = fpes_pkg::FPES_OP_NONE;
               wel_nxt = 1'b0;
            end else begin
               eng_nxt.cnt = eng_r.cnt - 24'h000001;
            end
         end
         fpes_pkg::ST_SUSW: begin
            if (lat_r <= 24'h000001) begin
               sv_nxt = eng_r;
               eng_nxt.st = fpes_pkg::ST_IDLE;
               eng_nxt.kind = fpes_pkg::FPES_OP_NONE;
            end else begin
               lat_nxt = lat_r - 24'h000001;
            end
         end
         default: eng_nxt.st = fpes_pkg::ST_IDLE;
      endcase
   end

   // Reset stands for power loss: the suspended slot and its flag are lost.
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         eng_r <= '0;
         sv_r <= '0;
         req_r <= '0;
         lat_r <= '0;
         sus_r <= 1'b0;
         wel_r <= 1'b0;
      end else if (CLK_EN) begin
         eng_r <= eng_nxt;
         sv_r <= sv_nxt;
         req_r <= req_nxt;
         lat_r <= lat_nxt;
         sus_r <= sus_nxt;
         wel_r <= wel_nxt;
      end
   end

   fpes_fifo #(.W($bits(fpes_pkg::fpes_req_s)), .DEPTH(2)) u_req_q (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .ce(CLK_EN),
      .in_valid(eng_r.st == fpes_pkg::ST_QUEUE),
      .in_ready(q_ready),
      .in_data(req_r),
      .out_valid(ARR_VALID),
      .out_ready(ARR_READY),
      .out_data(ARR_REQ)
   );

   assign BUSY = ~idle;
   assign WRITE_ENABLE_LATCH = wel_r;
   assign SUSPEND_FLAG = sus_r;
   assign PROT_ADDR = addr_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B || !CLK_EN);

   property p_wel;
      $rose(eng_r.st == fpes_pkg::ST_QUEUE) |-> $past(wel_r);
   endproperty
   a_wel: assert property (p_wel)
      else $error("operation started without write enable");

   property p_qe;
      $rose(eng_r.st == fpes_pkg::ST_QUEUE) && $past(opc_r) == fpes_pkg::OPC_QPP
         |-> $past(QUAD_LANE_ENABLE_BIT);
   endproperty
   a_qe: assert property (p_qe)
      else $error("quad program started with quad lanes disabled");

   property p_done;
      eng_r.st == fpes_pkg::ST_RUN && eng_r.cnt == 24'h000001 && !sus_go
         |=> !BUSY && !WRITE_ENABLE_LATCH;
   endproperty
   a_done: assert property (p_done)
      else $error("completion left busy or write enable set");

   property p_busy_fall;
      $fell(BUSY) |-> $past(eng_r.st) == fpes_pkg::ST_SUSW || $past(eng_r.cnt) <= 24'h000001;
   endproperty
   a_busy_fall: assert property (p_busy_fall)
      else $error("busy dropped before the operation finished");

   property p_sus;
      sus_go |=> SUSPEND_FLAG && BUSY ##[1:SUS_LAT] !BUSY;
   endproperty
   a_sus: assert property (p_sus)
      else $error("suspend did not settle within latency");

   property p_res;
      res_go |=> !SUSPEND_FLAG ##[0:RESUME_LIM] BUSY;
   endproperty
   a_res: assert property (p_res)
      else $error("resume did not restart the operation");

   property p_sus_ce;
      frm_end && opc_r == fpes_pkg::OPC_SUS && eng_r.kind == fpes_pkg::FPES_OP_CE && !sus_r
         |=> !SUSPEND_FLAG;
   endproperty
   a_sus_ce: assert property (p_sus_ce)
      else $error("chip erase was suspended");

   property p_sus_idle;
      frm_end && opc_r == fpes_pkg::OPC_SUS && idle |=> SUSPEND_FLAG == $past(sus_r);
   endproperty
   a_sus_idle: assert property (p_sus_idle)
      else $error("suspend acted while not busy");

   property p_partial;
      frm_end && !whole && idle |=> idle && wel_r == $past(wel_r);
   endproperty
   a_partial: assert property (p_partial)
      else $error("command with partial byte was executed");

   property p_bar_erase;
      $rose(eng_r.st == fpes_pkg::ST_QUEUE) && $past(sus_r) && fpes_pkg::is_erase(sv_r.kind)
         |-> !fpes_pkg::is_erase(eng_r.kind);
   endproperty
   a_bar_erase: assert property (p_bar_erase)
      else $error("erase started during erase suspend");

   property p_bar_prog;
      $rose(eng_r.st == fpes_pkg::ST_QUEUE) && $past(sus_r) && sv_r.kind == fpes_pkg::FPES_OP_PP
         |-> eng_r.kind != fpes_pkg::FPES_OP_PP;
   endproperty
   a_bar_prog: assert property (p_bar_prog)
      else $error("program started during program suspend");

   property p_ce_prot;
      $rose(eng_r.st == fpes_pkg::ST_QUEUE) && eng_r.kind == fpes_pkg::FPES_OP_CE
         |-> !$past(PROT_ANY);
   endproperty
   a_ce_prot: assert property (p_ce_prot)
      else $error("chip erase started with a protected region");

endmodule

//--- fpes_pkg.sv
/*
 Shared constants, types and decode functions for the flash program, erase
 and suspend sequencer. Assumes a 100 MHz reference clock (CLK_MHZ) for RESUME_CYC.
*/
package fpes_pkg;

   localparam logic [7:0] OPC_WREN = 8'h06;
   localparam logic [7:0] OPC_WRDI = 8'h04;
   localparam logic [7:0] OPC_PP = 8'h02;
   localparam logic [7:0] OPC_QPP = 8'h32;
   localparam logic [7:0] OPC_SE = 8'h20;
   localparam logic [7:0] OPC_BE32 = 8'h52;
   localparam logic [7:0] OPC_BE64 = 8'hd8;
   localparam logic [7:0] OPC_CE1 = 8'hc7;
   localparam logic [7:0] OPC_CE2 = 8'h60;
   localparam logic [7:0] OPC_SUS = 8'h75;
   localparam logic [7:0] OPC_RES = 8'h7a;

   localparam int PAGE_BYTES = 256;
   localparam int TMR_W = 24;
   localparam logic [9:0] NB_CMD = 10'h001;
   localparam logic [9:0] NB_ERASE = 10'h004;
   localparam logic [9:0] NB_PROG_MIN = 10'h005;
   localparam logic [9:0] NB_ADDR_LAST = 10'h003;
   localparam logic [9:0] NB_MAX = 10'h3ff;
   localparam logic [9:0] NB_PAGE = 10'h100;
   localparam logic [5:0] SYNC_RST = 6'h20;

   localparam int CLK_MHZ = 100;
   localparam int RESUME_NS = 200;
   localparam int RESUME_CYC = RESUME_NS * CLK_MHZ / 1000;

   typedef enum logic [2:0] {
      FPES_OP_NONE, FPES_OP_PP, FPES_OP_SE, FPES_OP_BE32, FPES_OP_BE64, FPES_OP_CE
   } fpes_op_e;

   typedef enum logic [1:0] {ST_IDLE, ST_QUEUE, ST_RUN, ST_SUSW} fpes_st_e;

   typedef struct packed {
      fpes_op_e kind;
      logic [23:0] addr;
      logic [8:0] nbytes;
   } fpes_req_s;

   typedef struct packed {
      fpes_st_e st;
      fpes_op_e kind;
      logic [TMR_W-1:0] cnt;
   } fpes_eng_s;

   function automatic fpes_op_e op_of(input logic [7:0] opc);
      case (opc)
         OPC_PP, OPC_QPP: op_of = FPES_OP_PP;
         OPC_SE: op_of = FPES_OP_SE;
         OPC_BE32: op_of = FPES_OP_BE32;
         OPC_BE64: op_of = FPES_OP_BE64;
         OPC_CE1, OPC_CE2: op_of = FPES_OP_CE;
         default: op_of = FPES_OP_NONE;
      endcase
   endfunction

   function automatic logic is_erase(input fpes_op_e k);
      is_erase = (k == FPES_OP_SE) || (k == FPES_OP_BE32) || (k == FPES_OP_BE64) ||
                 (k == FPES_OP_CE);
   endfunction

endpackage

//--- fpes_sync.sv
/*
 Two-stage synchroniser for a group of levels from another clock domain.
 Assumes each bit is sampled independently; callers must tolerate skew.
*/
`timescale 1ns/1ps

module fpes_sync #(
   parameter int W = 6,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input logic clk,
   input logic rst_b,
   input logic ce,
   input logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // Only the second stage reads the first one.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

//--- fpes_fifo.sv
/*
 Small FIFO with valid and ready on both sides.
 Assumes DEPTH is at least two; out_data is read straight from storage flops.
*/
`timescale 1ns/1ps

module fpes_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input logic clk,
   input logic rst_b,
   input logic ce,
   input logic in_valid,
   output logic in_ready,
   input logic [W-1:0] in_data,
   output logic out_valid,
   input logic out_ready,
   output logic [W-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign in_ready = cnt_r != (AW + 1)'(DEPTH);
   assign out_valid = cnt_r != '0;
   assign out_data = mem[rp_r];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (ce) begin
         if (push) wp_r <= bump(wp_r);
         if (pop) rp_r <= bump(rp_r);
         cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

   always_ff @(posedge clk) begin
      if (ce && push) mem[wp_r] <= in_data;
   end

endmodule

//--- fpes_host.sv
/*
 Host side of the serial link: frames bytes on clock, select and lanes.
 Assumes only the bench calls frame() and nothing else drives the link.
*/
`timescale 1ns/1ps

module fpes_host (
   output logic sclk,
   output logic cs_b,
   output logic [3:0] io
);
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      io = 4'h5;
   end

   task automatic pulse;
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
   endtask

   // Select stays low over every byte; quad frames send nibbles after the opcode.
   // Extra stray edges break the byte boundary on purpose.
   task automatic frame(input logic [7:0] b[$], input bit quad, input int extra);
      int n;
      cs_b = 1'b0;
      for (int i = 0; i < b.size(); i++) begin
         n = (quad && i > 0) ? 2 : 8;
         for (int k = n - 1; k >= 0; k--) begin
            io = (n == 2) ? (k ? b[i][7:4] : b[i][3:0]) : {3'h0, b[i][k]};
            pulse();
         end
      end
      repeat (extra) pulse();
      #40 cs_b = 1'b1;
      // Released lanes must not keep showing the last value.
      io = ~io;
      #80;
   endtask
endmodule

//--- fpes_top_bench.sv
/*
 Self-checking bench of the program, erase and suspend sequencer.
 Assumes fpes_host as the link partner and an array that stalls only through the first table row.
*/
`timescale 1ns/1ps

module fpes_top_bench;
   typedef struct packed {logic [7:0] opc; fpes_pkg::fpes_req_s req;} fpes_row_s;
   localparam logic [23:0] AD = 24'h123456;
   logic ref_clk, rst_b, clk_en, qe, hit, any, arr_ready, busy, write_enable_latch, suspend_flag, arr_valid;
   logic [23:0] prot_addr;
   logic sclk, cs_b;
   logic [3:0] io;
   logic [7:0] pb_raddr, pb_rdata;
   fpes_pkg::fpes_req_s arr_req;
   fpes_pkg::fpes_req_s reqs[$];
   int error_cnt = 0;
   int num_checks = 0;
   fpes_row_s rows [6] = '{
      '{8'h20, '{fpes_pkg::FPES_OP_SE, AD, 9'h000}},
      '{8'h52, '{fpes_pkg::FPES_OP_BE32, AD, 9'h000}},
      '{8'hd8, '{fpes_pkg::FPES_OP_BE64, AD, 9'h000}},
      '{8'hc7, '{fpes_pkg::FPES_OP_CE, AD, 9'h000}},
      '{8'h60, '{fpes_pkg::FPES_OP_CE, AD, 9'h000}},
      '{8'h02, '{fpes_pkg::FPES_OP_PP, AD, 9'h001}}};

   fpes_host u_fpes_host (.sclk(sclk), .cs_b(cs_b), .io(io));

   // The suspend latency keeps its default; only the long durations are shortened.
   fpes_top #(.PP_CYC(24'h000028), .SE_CYC(24'h000190), .BE32_CYC(24'h00003c),
      .BE64_CYC(24'h000050), .CE_CYC(24'h000190)) u_fpes_top (
      .REF_CLK(ref_clk), .RST_B(rst_b), .CLK_EN(clk_en), .LINK_SCLK(sclk),
      .LINK_CS_B(cs_b), .LINK_IO(io), .QUAD_LANE_ENABLE_BIT(qe), .PROT_HIT(hit),
      .PROT_ANY(any), .PROT_ADDR(prot_addr), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch),
      .SUSPEND_FLAG(suspend_flag), .ARR_VALID(arr_valid), .ARR_READY(arr_ready),
      .ARR_REQ(arr_req), .PB_RADDR(pb_raddr), .PB_RDATA(pb_rdata));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) if (arr_valid && arr_ready) reqs.push_back(arr_req);

   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_low(input int lim);
      int n = 0;
      while (busy !== 1'b0 && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      chk("busy_low", busy, 1'b0);
   endtask

   // Sends one frame, optionally after a write enable, and checks acceptance.
   task automatic op(input logic [7:0] q[$], input bit quad, input int extra, input bit we,
                     input bit acc);
      int n = 0;
      if (we) u_fpes_host.frame('{8'h06}, 1'b0, 0);
      u_fpes_host.frame(q, quad, extra);
      while (busy !== 1'b1 && n < 30) begin
         @(negedge ref_clk);
         n++;
      end
      chk("accepted", busy, acc);
   endtask

   task automatic do_reset;
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(negedge ref_clk);
   endtask

   task automatic stop_test;
      $display("Checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #800us;
      error_cnt++;
      $display("Error watchdog expected finish seen hang");
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] q[$];
      {rst_b, qe, hit, any, arr_ready, pb_raddr} = '0;
      clk_en = 1'b1;
      do_reset();
      chk("rst", {busy, write_enable_latch, suspend_flag, arr_valid}, 4'h0);
      u_fpes_host.frame('{8'h75}, 1'b0, 0);
      chk("sus_idle", {suspend_flag, busy}, 2'b00);
      // The array stalls through the first row; its word must wait in the buffer.
      for (int i = 0; i < 6; i++) begin
         q = '{rows[i].opc, AD[23:16], AD[15:8], AD[7:0]};
         if (rows[i].req.kind == fpes_pkg::FPES_OP_CE) q = '{rows[i].opc};
         if (rows[i].req.kind == fpes_pkg::FPES_OP_PP) q.push_back(8'h5a);
         op(q, 1'b0, 0, 1'b1, 1'b1);
         wait_low(600);
         chk("wel_clear", write_enable_latch, 1'b0);
         if (i == 0) chk("stall_hold", arr_valid, 1'b1);
         arr_ready <= 1'b1;
      end
      repeat (4) @(negedge ref_clk);
      chk("req_count", reqs.size(), 6);
      chk("prot_addr", prot_addr, AD);
      for (int i = 0; i < 6; i++) begin
         chk("req_kind", reqs[i].kind, rows[i].req.kind);
         if (i != 3 && i != 4) chk("req", reqs[i], rows[i].req);
      end
      $display("Test table done");
      q = '{8'h20, AD[23:16], AD[15:8], AD[7:0]};
      op(q, 1'b0, 0, 1'b0, 1'b0);
      op(q, 1'b0, 3, 1'b1, 1'b0);
      hit <= 1'b1;
      op(q, 1'b0, 0, 1'b1, 1'b0);
      hit <= 1'b0;
      any <= 1'b1;
      op('{8'hc7}, 1'b0, 0, 1'b1, 1'b0);
      any <= 1'b0;
      $display("Test refusals done");
      q = '{8'h32, AD[23:16], AD[15:8], 8'hfe};
      for (int k = 0; k < 258; k++) q.push_back(8'(k));
      op(q, 1'b1, 0, 1'b1, 1'b0);
      qe <= 1'b1;
      op(q, 1'b1, 0, 1'b1, 1'b1);
      wait_low(600);
      chk("quad_req", reqs[$], {3'h1, AD[23:8], 8'hfe, 9'h100});
      pb_raddr <= 8'hfe;
      repeat (3) @(negedge ref_clk);
      chk("wrap_fe", pb_rdata, 8'h00);
      pb_raddr <= 8'h00;
      repeat (3) @(negedge ref_clk);
      chk("wrap_00", pb_rdata, 8'h02);
      $display("Test quad done");
      q = '{8'h20, AD[23:16], AD[15:8], AD[7:0]};
      op(q, 1'b0, 0, 1'b1, 1'b1);
      u_fpes_host.frame('{8'h75}, 1'b0, 0);
      chk("sus_set", {suspend_flag, busy}, 2'b11);
      wait_low(250);
      op(q, 1'b0, 0, 1'b1, 1'b0);
      op('{8'h02, 8'h00, 8'h10, 8'h00, 8'h33}, 1'b0, 0, 1'b0, 1'b1);
      wait_low(600);
      chk("sus_kept", suspend_flag, 1'b1);
      u_fpes_host.frame('{8'h75}, 1'b0, 0);
      chk("sus_twice", {suspend_flag, busy}, 2'b10);
      u_fpes_host.frame('{8'h7a}, 1'b0, 0);
      @(negedge ref_clk);
      chk("resume", {suspend_flag, busy}, 2'b01);
      wait_low(600); // Any later suspend comes long after the latency.
      $display("Test suspend done");
      op('{8'hc7}, 1'b0, 0, 1'b1, 1'b1);
      u_fpes_host.frame('{8'h75}, 1'b0, 0);
      chk("ce_nosus", {suspend_flag, busy}, 2'b01);
      wait_low(600);
      op(q, 1'b0, 0, 1'b1, 1'b1);
      // A frozen clock enable must stretch the erase past its own duration.
      clk_en <= 1'b0;
      repeat (500) @(negedge ref_clk);
      chk("freeze", {busy, write_enable_latch}, 2'b11);
      clk_en <= 1'b1;
      u_fpes_host.frame('{8'h75}, 1'b0, 0);
      wait_low(250);
      do_reset();
      chk("rst_sus", suspend_flag, 1'b0);
      op('{8'h7a}, 1'b0, 0, 1'b0, 1'b0);
      $display("Test reset done");
      stop_test();
   end
endmodule
